// [verilog/pwmg_top.sv]
// Added by the designer: the AXI4-Lite register port.
module pwmg_top
  import pwmg_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Clock source ticks, one-cycle enables
  input  wire logic        clock_high_tick,
  input  wire logic        clock_low_tick,
  // Power management
  input  wire logic        sleep_req,
  // AXI4-Lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pin
  output logic             pwm_out_q
);
  logic [15:0]    on_time_q, off_time_q, hold_on_q, hold_off_q;
  logic [3:0]     hold_bytes_q;
  logic [6:0]     config_q;
  logic [15:0]    count_q;
  logic [3:0]     div_cnt_q;
  pwmg_state_type state_q;
  logic [3:0]     aw_addr_q;
  logic [31:0]    w_data_q;
  logic [3:0]     w_strb_q;
  logic           aw_have_q, w_have_q;
  logic           wr_fire, src_tick, div_tick, run, full_on, phase_end, hold_full, load_now;
  logic [3:0]     new_bytes;
  logic [3:0]     wr_bytes;
  logic           cfg_wr;

  assign run      = config_q[BIT_ENABLE] && !sleep_req;
  // Gated source: no ticks reach the counters while disabled
  assign src_tick = run && (config_q[BIT_CLK_SELECT] ? clock_low_tick : clock_high_tick);
  // Divider of value plus one; zero passes every tick
  assign div_tick = src_tick && (div_cnt_q == config_q[DIV_MSB:DIV_LSB]);
  assign full_on  = (off_time_q == 16'h0000);
  assign phase_end = div_tick && (count_q == 16'h0000);

  // AXI write capture, address and data in either order
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_q == ADDR_ON_TIME || aw_addr_q == ADDR_OFF_TIME || aw_addr_q == ADDR_CONFIG)
                      ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign cfg_wr = wr_fire && aw_addr_q == ADDR_CONFIG && w_strb_q[0];

  // Configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_q <= CONFIG_RESET;
    end else if (cfg_wr) begin
      config_q <= w_data_q[6:0];
    end
  end

  // Staging bytes: four written bytes arm a transfer
  always_comb begin
    wr_bytes = 4'h0;
    if (wr_fire && aw_addr_q == ADDR_ON_TIME) begin
      wr_bytes[1:0] = w_strb_q[1:0];
    end
    if (wr_fire && aw_addr_q == ADDR_OFF_TIME) begin
      wr_bytes[3:2] = w_strb_q[1:0];
    end
  end
  assign new_bytes = hold_bytes_q | wr_bytes;
  assign hold_full = (hold_bytes_q == 4'hF);
  // Full-on or disabled has no off-phase end to wait
  assign load_now  = hold_full && (full_on || !run || (state_q == ST_OFF && phase_end));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_on_q    <= ON_TIME_RESET;
      hold_off_q   <= OFF_TIME_RESET;
      hold_bytes_q <= 4'h0;
      on_time_q    <= ON_TIME_RESET;
      off_time_q   <= OFF_TIME_RESET;
    end else begin
      if (wr_fire && aw_addr_q == ADDR_ON_TIME) begin
        if (w_strb_q[0]) hold_on_q[7:0]  <= w_data_q[7:0];
        if (w_strb_q[1]) hold_on_q[15:8] <= w_data_q[15:8];
      end
      if (wr_fire && aw_addr_q == ADDR_OFF_TIME) begin
        if (w_strb_q[0]) hold_off_q[7:0]  <= w_data_q[7:0];
        if (w_strb_q[1]) hold_off_q[15:8] <= w_data_q[15:8];
      end
      // A write in the transfer cycle starts a fresh set
      if (load_now) begin
        on_time_q    <= hold_on_q;
        off_time_q   <= hold_off_q;
        hold_bytes_q <= wr_bytes;
      end else begin
        hold_bytes_q <= new_bytes;
      end
    end
  end

  // Pre-divider counter, held at zero while gated
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_cnt_q <= 4'h0;
    end else if (div_tick || cfg_wr) begin
      // Restart on config write so a smaller divider is never overrun
      div_cnt_q <= 4'h0;
    end else if (src_tick) begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  // Phase machine: n loads last n+1 ticks
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      state_q <= ST_OFF;
      count_q <= 16'h0000;
    end else if (phase_end) begin
      case (state_q)
        ST_OFF: begin
          state_q <= ST_ON;
          // Transfer edge: the new on time already applies
          count_q <= load_now ? hold_on_q : on_time_q;
        end
        ST_ON: begin
          state_q <= ST_OFF;
          count_q <= off_time_q;
        end
        default: begin
          state_q <= ST_OFF;
          count_q <= 16'h0000;
        end
      endcase
    end else if (div_tick) begin
      count_q <= count_q - 16'h0001;
    end
  end

  // Output pin level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_out_q <= 1'b0;
    end else if (!run) begin
      pwm_out_q <= config_q[BIT_INVERT];
    end else if (full_on) begin
      pwm_out_q <= 1'b1;
    end else if (on_time_q == 16'h0000) begin
      pwm_out_q <= 1'b0;
    end else begin
      pwm_out_q <= (state_q == ST_ON) ^ config_q[BIT_INVERT];
    end
  end

  // AXI read; returns active times, not the staged ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_ON_TIME:  s_axi_rdata <= {16'h0000, on_time_q};
        ADDR_OFF_TIME: s_axi_rdata <= {16'h0000, off_time_q};
        ADDR_CONFIG:   s_axi_rdata <= {25'h0, config_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // Checks
  out_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !run |=> pwm_out_q == $past(config_q[BIT_INVERT])) else $error("idle level wrong");
  gate_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !run |=> count_q == 16'h0000 && state_q == ST_OFF && div_cnt_q == 4'h0) else $error("not held");
  sleep_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_req |=> state_q == ST_OFF && count_q == 16'h0000) else $error("sleep not off");
  div_nodiv_a: assert property (@(posedge aclk) disable iff (!aresetn)
    src_tick && config_q[DIV_MSB:DIV_LSB] == 4'h0 |-> div_tick) else $error("no-div tick lost");
  div_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    div_cnt_q <= config_q[DIV_MSB:DIV_LSB] || !run) else $error("divider overrun");
  full_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run && full_on ##1 run |-> pwm_out_q) else $error("full on not high");
  phase_swap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run && phase_end && state_q == ST_ON |=> state_q == ST_OFF && count_q == $past(off_time_q))
    else $error("bad reload");
  count_dec_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run && div_tick && count_q != 16'h0000 |=> count_q == $past(count_q) - 16'h0001)
    else $error("no decrement");
  clk_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run && config_q[BIT_CLK_SELECT] |-> src_tick == clock_low_tick) else $error("wrong source");
  stage_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !hold_full |=> on_time_q == $past(on_time_q)) else $error("early transfer");
  cfg_rst_a: assert property (@(posedge aclk) !aresetn |=> config_q == 7'h00) else $error("cfg reset");
  cover_toggle_c: cover property (@(posedge aclk) disable iff (!aresetn) run && phase_end && state_q == ST_ON);
  cover_load_c: cover property (@(posedge aclk) disable iff (!aresetn) load_now && !full_on);
  cover_sleep_c: cover property (@(posedge aclk) disable iff (!aresetn) config_q[BIT_ENABLE] && sleep_req);
endmodule

// [verilog/pwmg_pkg.sv]
package pwmg_pkg;
  localparam logic [3:0]  ADDR_ON_TIME   = 4'h0;
  localparam logic [3:0]  ADDR_OFF_TIME  = 4'h4;
  localparam logic [3:0]  ADDR_CONFIG    = 4'h8;
  localparam logic [15:0] ON_TIME_RESET  = 16'h0000;
  localparam logic [15:0] OFF_TIME_RESET = 16'hFFFF;
  localparam logic [6:0]  CONFIG_RESET   = 7'h00;
  localparam int          BIT_ENABLE     = 0;
  localparam int          BIT_CLK_SELECT = 1;
  localparam int          BIT_INVERT     = 2;
  localparam int          DIV_LSB        = 3;
  localparam int          DIV_MSB        = 6;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  typedef enum logic [1:0] {
    ST_OFF = 2'h1,
    ST_ON  = 2'h2
  } pwmg_state_type;
endpackage

// [testbench/pwmg_load.sv]
module pwmg_load (
  // Pin side
  input  wire logic        aclk,
  input  wire logic        pin,
  // Last completed run lengths, in aclk cycles
  output logic [15:0]      high_len,
  output logic [15:0]      low_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        last_q = 1'h0;
  logic [15:0] run_q  = 16'h0000;
  // A fan input only sees levels, so measure each run between edges
  always_ff @(posedge aclk) begin
    last_q <= pin;
    if (pin != last_q) begin
      run_q <= 16'h0001;
      if (last_q) high_len <= run_q;
      else low_len <= run_q;
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end
endmodule

// [testbench/pwm_duty_frequency_generator_tb.sv]
module pwm_duty_frequency_generator_tb
  import pwmg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, hi_tick, lo_tick, sleep_req, pwm;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] high_len, low_len;
  int          n_fail, checked;

  pwmg_top uut (.aclk(aclk), .aresetn(aresetn), .clock_high_tick(hi_tick), .clock_low_tick(lo_tick),
    .sleep_req(sleep_req), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_out_q(pwm));
  pwmg_load load (.aclk(aclk), .pin(pwm), .high_len(high_len), .low_len(low_len));

  always #20 aclk = ~aclk;
  // Slow source ticks every other cycle
  always @(posedge aclk) lo_tick <= ~lo_tick;

  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'h0;
    if (n == 40) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    v = rdata;
    resp = rresp;
    rready <= 1'h0;
    if (n == 40) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  task automatic reset_values();
    rd(ADDR_ON_TIME, d, r);
    chk("on_reset", 32'h0000_0000, d);
    rd(ADDR_OFF_TIME, d, r);
    chk("off_reset", 32'h0000_FFFF, d);
    rd(ADDR_CONFIG, d, r);
    chk("cfg_reset", 32'h0000_0000, d);
    rd(4'hC, d, r);
    chk("unmapped_rresp", RESP_SLVERR, r);
    wr(4'hC, 32'h0000_00FF, r);
    chk("unmapped_bresp", RESP_SLVERR, r);
  endtask

  task automatic period(input logic [31:0] cfg, input logic [15:0] eh, input logic [15:0] el);
    wr(ADDR_CONFIG, cfg, r);
    repeat (40) @(posedge aclk);
    chk("high_len", eh, high_len);
    chk("low_len", el, low_len);
    wr(ADDR_CONFIG, {cfg[31:1], 1'h0}, r);
    repeat (20) @(posedge aclk);
    chk("idle_level", cfg[2], pwm);
  endtask

  task automatic staged();
    wr(ADDR_CONFIG, 32'h0000_0009, r);
    wr(ADDR_ON_TIME, 32'h0000_0005, r);
    rd(ADDR_ON_TIME, d, r);
    chk("on_active", 32'h0000_0002, d);
    wr(ADDR_OFF_TIME, 32'h0000_0003, r);
    repeat (60) @(posedge aclk);
    rd(ADDR_ON_TIME, d, r);
    chk("on_loaded", 32'h0000_0005, d);
    chk("high_len", 16'd12, high_len);
    wr(ADDR_CONFIG, 32'h0000_0000, r);
  endtask

  task automatic mid_reset();
    wr(ADDR_CONFIG, 32'h0000_007D, r);
    repeat (5) @(posedge aclk);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ADDR_CONFIG, d, r);
    chk("cfg_after_reset", 32'h0000_0000, d);
    rd(ADDR_ON_TIME, d, r);
    chk("on_after_reset", 32'h0000_0000, d);
    rd(ADDR_OFF_TIME, d, r);
    chk("off_after_reset", 32'h0000_FFFF, d);
    chk("pwm_after_reset", 32'h0000_0000, {31'h0, pwm});
  endtask

  task automatic hold(input logic [15:0] on, input logic [15:0] off, input logic lvl, input logic slp);
    logic ok;
    wr(ADDR_ON_TIME, {16'h0000, on}, r);
    wr(ADDR_OFF_TIME, {16'h0000, off}, r);
    wr(ADDR_CONFIG, 32'h0000_0009, r);
    sleep_req <= slp;
    repeat (10) @(posedge aclk);
    ok = 1'h1;
    repeat (30) begin
      @(posedge aclk);
      ok = ok & (pwm === lvl);
    end
    chk("hold_level", 32'h1, {31'h0, ok});
    sleep_req <= 1'h0;
    rd(ADDR_CONFIG, d, r);
    chk("cfg_kept", 32'h0000_0009, d);
    wr(ADDR_CONFIG, 32'h0000_0000, r);
  endtask

  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    hi_tick = 1'h1;
    lo_tick = 1'h0;
    sleep_req = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    n_fail = 0;
    checked = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    reset_values();
    wr(ADDR_ON_TIME, 32'h0000_0002, r);
    wr(ADDR_OFF_TIME, 32'h0000_0003, r);
    rd(ADDR_OFF_TIME, d, r);
    chk("off_disabled", 32'h0000_0003, d);
    period(32'h0000_0009, 16'd6, 16'd8);
    period(32'h0000_000D, 16'd8, 16'd6);
    period(32'h0000_0003, 16'd6, 16'd8);
    period(32'h0000_0001, 16'd3, 16'd4);
    period(32'h0000_0011, 16'd9, 16'd12);
    staged();
    hold(16'h0005, 16'h0000, 1'h1, 1'h0);
    hold(16'h0000, 16'h0003, 1'h0, 1'h0);
    hold(16'h0002, 16'h0003, 1'h0, 1'h1);
    mid_reset();
    tally_and_finish();
  end
endmodule
